// ### design/dos_defines.svh
// constants for the deserializer output and spread configuration block
// Functional notes
// - lowest gain select bit low turns equalization off; off is default
// - lowest bit high: upper three bits pick gain step 1.5 to 12 dB
// - gain selection comes from select pins or from a register
// - clock output slew and data/control slew have separate selects
// - slew select high gives maximum slew, low gives minimum slew
// - enabled spreading modulates both clock and data outputs
// - modulation frequency never exceeds 100 kHz
// - high range: code groups give divisors 2168, 1300, 868, 650
// - low range divisors 620, 370, 258, 192; low bits pick deviation (at the 40 MHz clock the code raises 370, 258 and 192 to 400)
// - spread configuration comes from strap pins or from a register
`ifndef DOS_DEFINES_SVH
`define DOS_DEFINES_SVH

// register byte offsets
`define DOS_OFS_CTRL 5'h00
`define DOS_OFS_GAIN 5'h04
`define DOS_OFS_SLEW 5'h08
`define DOS_OFS_SPREAD 5'h0C
`define DOS_OFS_STATUS 5'h10
`define DOS_OFS_MODPOS 5'h14

// control register fields
`define DOS_CTRL_GAIN_REG 0
`define DOS_CTRL_SLEW_REG 1
`define DOS_CTRL_SPREAD_REG 2
// slew register fields
`define DOS_SLEW_CLK 0
`define DOS_SLEW_DATA 1
// spread register fields
`define DOS_SPREAD_LOW 4
// status register fields
`define DOS_ST_EQ_ON 0
`define DOS_ST_EQ_STEP 1
`define DOS_ST_CLK_SLEW 4
`define DOS_ST_DATA_SLEW 5
`define DOS_ST_SPREAD_ON 6
`define DOS_ST_DEV 7
`define DOS_ST_DIV 16

// reset values
`define DOS_RST_CTRL 3'h0
`define DOS_RST_GAIN 4'h0
`define DOS_RST_SLEW 2'h0
`define DOS_RST_SPREAD 5'h00

// modulation divisors, high range then low range
`define DOS_DIV_HI_0 12'd2168
`define DOS_DIV_HI_1 12'd1300
`define DOS_DIV_HI_2 12'd868
`define DOS_DIV_HI_3 12'd650
`define DOS_DIV_LO_0 12'd620
`define DOS_DIV_LO_1 12'd370
`define DOS_DIV_LO_2 12'd258
`define DOS_DIV_LO_3 12'd192

// timing
`define DOS_CLK_HZ 40000000
`define DOS_MOD_MAX_HZ 100000
// least divisor that keeps modulation at or under the limit, rounded up
`define DOS_MIN_MOD_DIV \
	((`DOS_CLK_HZ + `DOS_MOD_MAX_HZ - 1) / `DOS_MOD_MAX_HZ)

`endif

// ### design/dos_pkg.sv
// types shared by the output and spread configuration block
package dos_pkg;

	typedef struct packed {
		logic [2:0] step;
		logic on;
	} dos_gain_t;

	typedef struct packed {
		logic data_max;
		logic clk_max;
	} dos_slew_t;

	typedef struct packed {
		logic low_range;
		logic [3:0] code;
	} dos_spread_t;

	// deviation encoding follows the two low code bits
	typedef enum logic [1:0] {
		DOS_DEV_2P0,
		DOS_DEV_0P5,
		DOS_DEV_1P0,
		DOS_DEV_1P5
	} dos_dev_t;

	typedef struct packed {
		logic clk_en;
		logic data_en;
		dos_dev_t dev;
	} dos_spread_out_t;

endpackage

// ### design/dos_tri_mod.sv
// triangular center-spread modulation profile generator
`timescale 1ns/1ps
module dos_tri_mod #(
	parameter int W = 12
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic run,
	input wire logic [W-1:0] div,
	output logic signed [W-1:0] pos_ff
);
	logic [W-1:0] cnt_ff;
	logic [W-1:0] nxt_cnt;
	logic signed [W-1:0] nxt_pos;
	logic [W-1:0] half;
	logic [W-1:0] tri_val;

	if (W < 12) begin : g_w_check
		$error("dos_tri_mod: W too small for divisors");
	end

	always_comb begin
		half = div >> 1;
		nxt_cnt = '0;
		nxt_pos = '0;
		tri_val = '0;
		if (run) begin
			// restart when a smaller divisor is picked mid-period
			if (cnt_ff >= div - 1'b1)
				nxt_cnt = '0;
			else
				nxt_cnt = cnt_ff + 1'b1;
			// ramp up over the first half, down over the second
			if (cnt_ff < half)
				tri_val = cnt_ff;
			else
				tri_val = div - cnt_ff;
			// centred on zero so the spread is symmetric
			nxt_pos = $signed(tri_val - (half >> 1));
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cnt_ff <= '0;
			pos_ff <= '0;
		end else begin
			cnt_ff <= nxt_cnt;
			pos_ff <= nxt_pos;
		end
	end
endmodule

// ### design/dos_output_spread_config.sv
// output slew, receive gain and spread configuration with avalon registers
//
// The Avalon-MM register port and the address map were decided locally.
`timescale 1ns/1ps
`include "dos_defines.svh"
module dos_output_spread_config #(
	parameter int DIV_W = 12
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [3:0] rx_gain_select_pin,
	input wire logic clock_out_slew_select_pin,
	input wire logic data_out_slew_select_pin,
	input wire logic [3:0] spread_config_pin,
	input wire logic low_freq_range_select_pin,
	output dos_pkg::dos_gain_t rx_gain_ff,
	output dos_pkg::dos_slew_t out_slew_ff,
	output dos_pkg::dos_spread_out_t spread_ff,
	output logic signed [DIV_W-1:0] spread_pos_ff
);
	import dos_pkg::*;

	// the status word carries the divisor in a 16-bit field
	if (DIV_W < 12 || DIV_W > 16) begin : g_div_w_check
		$error("dos_output_spread_config: DIV_W must be 12 to 16");
	end
	if (`DOS_MIN_MOD_DIV > 2168) begin : g_clk_check
		$error("dos_output_spread_config: clock too fast");
	end

	localparam logic [DIV_W-1:0] MIN_DIV = DIV_W'(`DOS_MIN_MOD_DIV);

	// divisor for a nonzero code; bumped up when the clock rate would
	// otherwise push modulation over the limit
	function automatic logic [DIV_W-1:0] mod_div(input logic [3:0] code,
			input logic low);
		logic [1:0] grp;
		logic [DIV_W-1:0] d;
		grp = 2'((code - 4'h1) >> 2);
		d = '0;
		if (low) begin
			case (grp)
			2'h0: d = DIV_W'(`DOS_DIV_LO_0);
			2'h1: d = DIV_W'(`DOS_DIV_LO_1);
			2'h2: d = DIV_W'(`DOS_DIV_LO_2);
			default: d = DIV_W'(`DOS_DIV_LO_3);
			endcase
		end else begin
			case (grp)
			2'h0: d = DIV_W'(`DOS_DIV_HI_0);
			2'h1: d = DIV_W'(`DOS_DIV_HI_1);
			2'h2: d = DIV_W'(`DOS_DIV_HI_2);
			default: d = DIV_W'(`DOS_DIV_HI_3);
			endcase
		end
		if (d < MIN_DIV)
			d = MIN_DIV;
		return d;
	endfunction

	// one-hot register decode shared by the read mux and the write path;
	// unaligned or unmapped addresses hit nothing, so they read zero
	function automatic logic [5:0] reg_hit(input logic [4:0] a);
		logic [5:0] h;
		h = '0;
		if (a == `DOS_OFS_CTRL) begin
			h[0] = 1'b1;
		end else if (a == `DOS_OFS_GAIN) begin
			h[1] = 1'b1;
		end else if (a == `DOS_OFS_SLEW) begin
			h[2] = 1'b1;
		end else if (a == `DOS_OFS_SPREAD) begin
			h[3] = 1'b1;
		end else if (a == `DOS_OFS_STATUS) begin
			h[4] = 1'b1;
		end else if (a == `DOS_OFS_MODPOS) begin
			h[5] = 1'b1;
		end
		return h;
	endfunction

	// code zero is the disable setting in both ranges
	function automatic logic spread_active(input logic [3:0] code);
		return code != 4'h0;
	endfunction

	// pin synchronisers; straps may move at any time, so nothing reads
	// the first stage but the second
	logic [10:0] pin_meta_ff;
	logic [10:0] pin_sync_ff;
	logic [10:0] pin_raw;
	logic [10:0] nxt_pin_meta;
	logic [10:0] nxt_pin_sync;
	assign pin_raw = {low_freq_range_select_pin, spread_config_pin,
		data_out_slew_select_pin, clock_out_slew_select_pin,
		rx_gain_select_pin};

	always_comb begin
		nxt_pin_meta = pin_raw;
		nxt_pin_sync = pin_meta_ff;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pin_meta_ff <= '0;
			pin_sync_ff <= '0;
		end else begin
			pin_meta_ff <= nxt_pin_meta;
			pin_sync_ff <= nxt_pin_sync;
		end
	end

	logic [3:0] pin_gain;
	logic pin_clk_slew;
	logic pin_data_slew;
	dos_spread_t pin_spread;
	assign pin_gain = pin_sync_ff[3:0];
	assign pin_clk_slew = pin_sync_ff[4];
	assign pin_data_slew = pin_sync_ff[5];
	assign pin_spread = pin_sync_ff[10:6];

	// software registers
	logic [2:0] ctrl_ff;
	logic [3:0] gain_reg_ff;
	logic [1:0] slew_reg_ff;
	dos_spread_t spread_reg_ff;
	logic [2:0] nxt_ctrl;
	logic [3:0] nxt_gain_reg;
	logic [1:0] nxt_slew_reg;
	dos_spread_t nxt_spread_reg;

	// bus slave state
	logic [31:0] nxt_readdata;
	logic nxt_waitrequest;
	logic [31:0] rd_mux;
	logic [31:0] status_word;
	logic wr_take;
	logic [5:0] hit;
	// decoded once so the read mux and the write path agree
	assign hit = reg_hit(avs_address);

	// effective selections
	logic [3:0] sel_gain;
	logic sel_clk_slew;
	logic sel_data_slew;
	dos_spread_t sel_spread;
	dos_gain_t nxt_rx_gain;
	dos_slew_t nxt_out_slew;
	dos_spread_out_t nxt_spread;
	logic [DIV_W-1:0] div_ff;
	logic [DIV_W-1:0] nxt_div;

	always_comb begin
		status_word = '0;
		status_word[`DOS_ST_EQ_ON] = rx_gain_ff.on;
		status_word[`DOS_ST_EQ_STEP +: 3] = rx_gain_ff.step;
		status_word[`DOS_ST_CLK_SLEW] = out_slew_ff.clk_max;
		status_word[`DOS_ST_DATA_SLEW] = out_slew_ff.data_max;
		status_word[`DOS_ST_SPREAD_ON] = spread_ff.clk_en;
		status_word[`DOS_ST_DEV +: 2] = spread_ff.dev;
		status_word[`DOS_ST_DIV +: DIV_W] = div_ff;
	end

	always_comb begin
		rd_mux = '0;
		if (hit[0]) begin
			rd_mux[2:0] = ctrl_ff;
		end else if (hit[1]) begin
			rd_mux[3:0] = gain_reg_ff;
		end else if (hit[2]) begin
			rd_mux[1:0] = slew_reg_ff;
		end else if (hit[3]) begin
			rd_mux[4:0] = spread_reg_ff;
		end else if (hit[4]) begin
			rd_mux = status_word;
		end else if (hit[5]) begin
			rd_mux = 32'(spread_pos_ff);
		end
	end

	// one wait state: request seen, then ack with waitrequest low
	always_comb begin
		nxt_waitrequest = 1'b1;
		nxt_readdata = avs_readdata;
		if (avs_waitrequest && (avs_read || avs_write)) begin
			nxt_waitrequest = 1'b0;
			if (avs_read)
				nxt_readdata = rd_mux;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= '0;
		end else begin
			avs_waitrequest <= nxt_waitrequest;
			avs_readdata <= nxt_readdata;
		end
	end

	// writes land on the edge that sees waitrequest low
	assign wr_take = avs_write && !avs_waitrequest && avs_byteenable[0];

	always_comb begin
		nxt_ctrl = ctrl_ff;
		nxt_gain_reg = gain_reg_ff;
		nxt_slew_reg = slew_reg_ff;
		nxt_spread_reg = spread_reg_ff;
		if (wr_take) begin
			if (hit[0]) begin
				nxt_ctrl = avs_writedata[2:0];
			end else if (hit[1]) begin
				nxt_gain_reg = avs_writedata[3:0];
			end else if (hit[2]) begin
				nxt_slew_reg = avs_writedata[1:0];
			end else if (hit[3]) begin
				nxt_spread_reg = avs_writedata[4:0];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ctrl_ff <= `DOS_RST_CTRL;
			gain_reg_ff <= `DOS_RST_GAIN;
			slew_reg_ff <= `DOS_RST_SLEW;
			spread_reg_ff <= `DOS_RST_SPREAD;
		end else begin
			ctrl_ff <= nxt_ctrl;
			gain_reg_ff <= nxt_gain_reg;
			slew_reg_ff <= nxt_slew_reg;
			spread_reg_ff <= nxt_spread_reg;
		end
	end

	// source selection, pins unless software claims the setting
	always_comb begin
		if (ctrl_ff[`DOS_CTRL_GAIN_REG])
			sel_gain = gain_reg_ff;
		else
			sel_gain = pin_gain;
		if (ctrl_ff[`DOS_CTRL_SLEW_REG]) begin
			sel_clk_slew = slew_reg_ff[`DOS_SLEW_CLK];
			sel_data_slew = slew_reg_ff[`DOS_SLEW_DATA];
		end else begin
			sel_clk_slew = pin_clk_slew;
			sel_data_slew = pin_data_slew;
		end
		if (ctrl_ff[`DOS_CTRL_SPREAD_REG])
			sel_spread = spread_reg_ff;
		else
			sel_spread = pin_spread;
	end

	always_comb begin
		// upper bits are ignored while equalization is off
		nxt_rx_gain.on = sel_gain[0];
		nxt_rx_gain.step = sel_gain[0] ? sel_gain[3:1] : 3'h0;
		nxt_out_slew.clk_max = sel_clk_slew;
		nxt_out_slew.data_max = sel_data_slew;
		// zero code is the disable the configuring party must use
		// above the spread range; no clock sensing is done here
		nxt_spread.clk_en = spread_active(sel_spread.code);
		nxt_spread.data_en = spread_active(sel_spread.code);
		nxt_spread.dev = dos_dev_t'(sel_spread.code[1:0]);
		// divisor stays zero while off; the profile generator idles because its run input follows clk_en
		if (spread_active(sel_spread.code))
			nxt_div = mod_div(sel_spread.code, sel_spread.low_range);
		else
			nxt_div = '0;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rx_gain_ff <= '0;
			out_slew_ff <= '0;
			spread_ff <= '0;
			div_ff <= '0;
		end else begin
			rx_gain_ff <= nxt_rx_gain;
			out_slew_ff <= nxt_out_slew;
			spread_ff <= nxt_spread;
			div_ff <= nxt_div;
		end
	end

	dos_tri_mod #(
		.W(DIV_W)
	) u_tri (
		.ref_clk(ref_clk),
		.rst(rst),
		.run(spread_ff.clk_en),
		.div(div_ff),
		.pos_ff(spread_pos_ff)
	);
endmodule

// ### sim/dos_output_spread_config_checker.sv
// assertions on the ports of the output and spread configuration block
`timescale 1ns/1ps
module dos_output_spread_config_checker #(
	parameter int DIV_W = 12
) (
	input logic ref_clk,
	input logic rst,
	input logic [4:0] avs_address,
	input logic avs_read,
	input logic avs_write,
	input logic [3:0] avs_byteenable,
	input logic [31:0] avs_writedata,
	input logic [31:0] avs_readdata,
	input logic avs_waitrequest,
	input logic [3:0] rx_gain_select_pin,
	input logic clock_out_slew_select_pin,
	input logic data_out_slew_select_pin,
	input logic [3:0] spread_config_pin,
	input logic low_freq_range_select_pin,
	input dos_pkg::dos_gain_t rx_gain_ff,
	input dos_pkg::dos_slew_t out_slew_ff,
	input dos_pkg::dos_spread_out_t spread_ff,
	input logic signed [DIV_W-1:0] spread_pos_ff
);
	import dos_pkg::*;
	logic [2:0] ctl_ff;
	logic [2:0] age_ff;
	// source-select mirror; age keeps reset-time syncs out of the checks
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ctl_ff <= 3'h0;
			age_ff <= 3'h0;
		end else begin
			age_ff <= age_ff + {2'h0, age_ff != 3'h7};
			if (avs_write && !avs_waitrequest && avs_address == 5'h00
				&& avs_byteenable[0]) begin
				ctl_ff <= avs_writedata[2:0];
			end
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	chk_req_ack:
	assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest) else $error("request not acked");
	chk_ack_once:
	assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("ack longer than one cycle");
	chk_unmapped_zero:
	assert property (avs_read && avs_waitrequest && avs_address > 5'h14
		|=> avs_readdata == 32'h0) else $error("unmapped read not zero");
	chk_gain_off:
	assert property (!rx_gain_ff.on |-> rx_gain_ff.step == 3'h0)
		else $error("gain step while off");
	chk_gain_pins:
	assert property ((age_ff == 3'h7 && !ctl_ff[0]) [*4] |-> rx_gain_ff ==
		{$past(rx_gain_select_pin[0], 3) ? $past(rx_gain_select_pin[3:1], 3)
		: 3'h0, $past(rx_gain_select_pin[0], 3)}) else $error("gain decode");
	chk_slew_pins:
	assert property ((age_ff == 3'h7 && !ctl_ff[1]) [*4] |-> out_slew_ff ==
		{$past(data_out_slew_select_pin, 3), $past(clock_out_slew_select_pin, 3)})
		else $error("slew decode");
	chk_spread_pins:
	assert property ((age_ff == 3'h7 && !ctl_ff[2]) [*4] |-> spread_ff ==
		{{2{$past(spread_config_pin, 3) != 4'h0}}, $past(spread_config_pin[1:0], 3)})
		else $error("spread decode");
	chk_pos_idle:
	assert property (!spread_ff.clk_en [*3] |-> spread_pos_ff == '0)
		else $error("modulation while off");
	cover property (avs_write && !avs_waitrequest);
	cover property (avs_read && !avs_waitrequest);
	cover property (spread_ff.clk_en && spread_pos_ff > 0);
endmodule
bind dos_output_spread_config dos_output_spread_config_checker #(
	.DIV_W(DIV_W)) dos_output_spread_config_checker_i (.*);

// ### sim/dos_sink_model.sv
// downstream receiver model that times the spread modulation period
`timescale 1ns/1ps
module dos_sink_model (
	input logic ref_clk,
	input logic rst,
	input logic signed [11:0] pos,
	output logic [15:0] period_ff
);
	logic signed [11:0] p1_ff;
	logic signed [11:0] p2_ff;
	logic [15:0] cnt_ff;
	always_ff @(posedge ref_clk) begin
		p1_ff <= pos;
		p2_ff <= p1_ff;
		cnt_ff <= cnt_ff + 16'h0001;
		if (rst) begin
			cnt_ff <= 16'h0000;
			period_ff <= 16'h0000;
		end else if (p2_ff > p1_ff && pos > p1_ff) begin
			// one trough per triangle, so trough spacing is the period
			period_ff <= cnt_ff;
			cnt_ff <= 16'h0001;
		end
	end
endmodule

// ### sim/dos_output_spread_config_tb.sv
// self-checking bench for the output and spread configuration block
`timescale 1ns/1ps
module dos_output_spread_config_tb;
	import dos_pkg::*;
	logic ref_clk, rst, avs_read, avs_write, avs_waitrequest;
	logic [4:0] avs_address;
	logic [3:0] avs_byteenable, rx_gain_select_pin, spread_config_pin;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic clock_out_slew_select_pin, data_out_slew_select_pin;
	logic low_freq_range_select_pin;
	dos_gain_t rx_gain_ff;
	dos_slew_t out_slew_ff;
	dos_spread_out_t spread_ff;
	logic signed [11:0] spread_pos_ff;
	logic [15:0] period;
	int err_count, num_checks;
	logic [11:0] div_hi [4] = '{12'h878, 12'h514, 12'h364, 12'h28A};
	logic [11:0] div_lo [4] = '{12'h26C, 12'h172, 12'h102, 12'h0C0};
	dos_output_spread_config dos_output_spread_config_i (.*);
	dos_sink_model dos_sink_model_i (.ref_clk, .rst, .pos(spread_pos_ff),
		.period_ff(period));
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	initial begin
		#2000000;
		err_count++;
		wrap_up();
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		avs_write <= w;
		avs_read <= !w;
		avs_address <= a;
		avs_writedata <= d;
		@(posedge ref_clk);
		// only the watchdog ends a wait that never gets its answer
		while (avs_waitrequest !== 1'b0) begin
			@(posedge ref_clk);
		end
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic settle();
		repeat (5) @(posedge ref_clk);
	endtask
	task automatic t_reset();
		avs_byteenable <= 4'h0;
		bus(1'b1, 5'h00, 32'h7);
		avs_byteenable <= 4'hF;
		for (int i = 0; i < 4; i++) begin
			bus(1'b0, 5'(i * 4), 32'h0);
			chk(q, 32'h0);
		end
		bus(1'b0, 5'h1C, 32'h0);
		chk(q, 32'h0);
		chk(32'(rx_gain_ff), 32'h0);
	endtask
	task automatic t_gain();
		for (int i = 0; i < 16; i++) begin
			rx_gain_select_pin <= 4'(i);
			settle();
			chk(32'(rx_gain_ff), {28'h0, i[0] ? 3'(i >> 1) : 3'h0, i[0]});
		end
		bus(1'b1, 5'h00, 32'h1);
		bus(1'b1, 5'h04, 32'h6);
		settle();
		chk(32'(rx_gain_ff), 32'h0);
		bus(1'b1, 5'h04, 32'hB);
		settle();
		chk(32'(rx_gain_ff), 32'hB);
		bus(1'b1, 5'h00, 32'h0);
	endtask
	task automatic t_slew();
		for (int i = 0; i < 4; i++) begin
			{data_out_slew_select_pin, clock_out_slew_select_pin} <= 2'(i);
			settle();
			chk(32'(out_slew_ff), 32'(i));
			bus(1'b1, 5'h00, 32'h2);
			bus(1'b1, 5'h08, 32'(3 - i));
			settle();
			chk(32'(out_slew_ff), 32'(3 - i));
			bus(1'b1, 5'h00, 32'h0);
		end
	endtask
	task automatic t_spread();
		logic [11:0] d;
		logic [1:0] g;
		// 40 MHz clock sits below the band where spreading must stay off
		bus(1'b1, 5'h00, 32'h4);
		for (int i = 0; i < 32; i++) begin
			g = 2'((i % 16 - 1) / 4);
			d = i[4] ? div_lo[g] : div_hi[g];
			// 400 is the least divisor that keeps modulation at 100 kHz
			d = (d < 12'h190) ? 12'h190 : d;
			d = (i % 16 == 0) ? 12'h0 : d;
			bus(1'b1, 5'h0C, 32'(i));
			settle();
			chk(32'(spread_ff), {28'h0, {2{i % 16 != 0}}, 2'(i)});
			bus(1'b0, 5'h10, 32'h0);
			chk({17'h0, q[27:16], q[8:7], q[6]}, {17'h0, d, 2'(i), i % 16 != 0});
		end
		bus(1'b1, 5'h0C, 32'h0F);
		repeat (2000) @(posedge ref_clk);
		chk(32'(period), 32'h28A);
		bus(1'b1, 5'h0C, 32'h11);
		repeat (2000) @(posedge ref_clk);
		chk(32'(period), 32'h26C);
		bus(1'b1, 5'h00, 32'h0);
		spread_config_pin <= 4'h9;
		low_freq_range_select_pin <= 1'b1;
		settle();
		chk(32'(spread_ff), 32'hD);
		repeat (2000) @(posedge ref_clk);
		chk(32'(period), 32'h190);
		spread_config_pin <= 4'h0;
		settle();
		chk(32'(spread_ff) | 32'(spread_pos_ff), 32'h0);
		bus(1'b0, 5'h14, 32'h0);
		chk(q, 32'h0);
	endtask
	initial begin
		rst = 1'b1;
		{avs_read, avs_write, avs_address, avs_writedata} = '0;
		avs_byteenable = 4'hF;
		{rx_gain_select_pin, spread_config_pin} = 8'h00;
		{clock_out_slew_select_pin, data_out_slew_select_pin} = 2'h0;
		low_freq_range_select_pin = 1'b0;
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		t_reset();
		t_gain();
		t_slew();
		t_spread();
		wrap_up();
	end
endmodule
